/* src/uart_ef_pkg.sv */
// Constants, types and field layouts for the quad UART enhanced feature block
package uart_ef_pkg;
   localparam int CHANNELS = 4;
   localparam int SYNC_W = 4 * CHANNELS + 2;

   // Register offsets, per channel
   localparam logic [3:0] OFS_INT_ENABLE = 4'h0;
   localparam logic [3:0] OFS_INT_STATUS = 4'h1;
   localparam logic [3:0] OFS_MODEM_CONTROL = 4'h2;
   localparam logic [3:0] OFS_LINE_STATUS = 4'h3;
   localparam logic [3:0] OFS_MODEM_STATUS = 4'h4;
   localparam logic [3:0] OFS_SCRATCHPAD = 4'h5;
   localparam logic [3:0] OFS_FEATURE_CONTROL = 4'h6;
   localparam logic [3:0] OFS_TRIGGER_LEVEL = 4'h7;
   localparam logic [3:0] OFS_ENHANCED_FEATURE = 4'h8;
   localparam logic [3:0] OFS_RESUME_ONE = 4'h9;
   localparam logic [3:0] OFS_RESUME_TWO = 4'ha;
   localparam logic [3:0] OFS_STOP_ONE = 4'hb;
   localparam logic [3:0] OFS_STOP_TWO = 4'hc;

   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_INT_STATUS = 8'h01;
   localparam logic [7:0] RST_LINE_STATUS = 8'h60;
   localparam logic [7:0] RST_SCRATCHPAD = 8'hff;
   localparam logic [7:0] RST_FIFO_READY = 8'hff;

   // Field positions
   localparam int EF_SPECIAL = 5;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_AUTO_CTS = 7;
   localparam int IE_RX_TRIGGER = 0;
   localparam int IE_SPECIAL = 5;
   localparam int MC_DTR = 0;
   localparam int MC_RTS = 1;
   localparam int MC_INT_OUT_EN = 3;
   localparam int IS_NONE = 0;
   localparam int IS_RX_TRIGGER = 2;
   localparam int IS_SPECIAL = 4;
   localparam int IS_STOP = 5;

   // Receive flow select codes, enhanced_feature bits 1:0
   localparam logic [1:0] RXF_PAIR_TWO = 2'b01;
   localparam logic [1:0] RXF_PAIR_ONE = 2'b10;
   localparam logic [1:0] RXF_BOTH = 2'b11;

   // RTS hysteresis in characters per feature_control bits 1:0
   localparam logic [7:0] HYST_NEXT = 8'h08;
   localparam logic [7:0] HYST_STEP = 8'h04;

   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic [1:0] chan;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rx_char_t;

   typedef struct packed {
      logic store;
      logic special;
      logic stop_hit;
      logic resume_hit;
   } screen_t;

   typedef struct packed {
      logic [7:0] int_enable;
      logic [7:0] modem_control;
      logic [7:0] line_status;
      logic [7:0] modem_status;
      logic [7:0] scratchpad;
      logic [7:0] feature_control;
      logic [7:0] trigger_level;
      logic [7:0] enhanced_feature;
      logic [7:0] resume_one;
      logic [7:0] resume_two;
      logic [7:0] stop_one;
      logic [7:0] stop_two;
      logic flag_trigger;
      logic flag_special;
      logic flag_stop;
      logic above_trigger;
      logic rts_high;
      logic sw_stopped;
      logic store;
      logic [7:0] store_data;
      logic rx_ready_n;
      logic tx_ready_n;
      logic tx_line;
      logic infrared_tx_out_line;
   } chan_state_t;

   typedef struct packed {
      chan_state_t [CHANNELS-1:0] chan;
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic [SYNC_W-1:0] sync3;
      logic [SYNC_W-1:0] pins;
      logic rd_prev;
      logic [7:0] rdata;
   } state_t;
endpackage

/* src/rx_char_screen.sv */
// Received character classifier for flow and special character handling
module rx_char_screen
   import uart_ef_pkg::*;
(
   input wire rx_char_t char_i,
   input wire logic [7:0] enhanced_feature_i,
   input wire logic [7:0] resume_one_i,
   input wire logic [7:0] resume_two_i,
   input wire logic [7:0] stop_one_i,
   input wire logic [7:0] stop_two_i,
   output screen_t screen_o
);
   logic [1:0] rx_sel;
   logic special_on;
   logic hit_stop_one;
   logic hit_stop_two;
   logic hit_res_one;
   logic hit_res_two;
   logic flow_stop;
   logic flow_res;

   always_comb begin
      rx_sel = enhanced_feature_i[1:0];
      special_on = enhanced_feature_i[EF_SPECIAL];
      hit_stop_one = (char_i.data == stop_one_i);
      hit_stop_two = (char_i.data == stop_two_i);
      hit_res_one = (char_i.data == resume_one_i);
      hit_res_two = (char_i.data == resume_two_i);
      flow_stop = 1'b0;
      flow_res = 1'b0;
      case (rx_sel)
         RXF_PAIR_ONE: begin
            flow_stop = hit_stop_one;
            flow_res = hit_res_one;
         end
         RXF_PAIR_TWO: begin
            flow_stop = hit_stop_two;
            flow_res = hit_res_two;
         end
         RXF_BOTH: begin
            flow_stop = hit_stop_one | hit_stop_two;
            flow_res = hit_res_one | hit_res_two;
         end
         default: begin
            flow_stop = 1'b0;
            flow_res = 1'b0;
         end
      endcase
      screen_o.stop_hit = char_i.valid & flow_stop;
      screen_o.resume_hit = char_i.valid & flow_res;
      // Special match; pair two stop is swallowed by flow control only when the flow select is pair two alone
      screen_o.special = char_i.valid & special_on & hit_stop_two;
      if (rx_sel == RXF_PAIR_TWO && special_on && hit_stop_two) begin
         screen_o.store = 1'b0;
      end else if (special_on && hit_stop_two) begin
         screen_o.store = char_i.valid;
      end else begin
         screen_o.store = char_i.valid & ~flow_stop & ~flow_res;
      end
   end
endmodule // rx_char_screen

/* src/uart_enhanced_flow_control.sv */
// Quad channel enhanced flow control, status and register block
module uart_enhanced_flow_control
   import uart_ef_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire bus_req_t bus_i,
   input wire logic fifo_status_select_n_i,
   output logic [7:0] bus_rdata_o,
   output logic bus_rdata_oe_o,
   input wire rx_char_t [CHANNELS-1:0] rx_char_i,
   input wire logic [CHANNELS-1:0][7:0] rx_fifo_level_i,
   input wire logic [CHANNELS-1:0] tx_fifo_full_i,
   input wire logic [CHANNELS-1:0] tx_empty_i,
   input wire logic [CHANNELS-1:0] tx_bit_i,
   input wire logic [CHANNELS-1:0] infrared_tx_out_bit_i,
   input wire logic [CHANNELS-1:0] cts_n_i,
   input wire logic [CHANNELS-1:0] dsr_n_i,
   input wire logic [CHANNELS-1:0] ri_n_i,
   input wire logic [CHANNELS-1:0] cd_n_i,
   input wire logic mode_68_i,
   input wire logic interrupt_output_select_i,
   output logic [CHANNELS-1:0] rx_fifo_write_o,
   output logic [CHANNELS-1:0][7:0] rx_fifo_wdata_o,
   output logic [CHANNELS-1:0] tx_enable_o,
   output logic [CHANNELS-1:0] tx_o,
   output logic [CHANNELS-1:0] infrared_tx_out_o,
   output logic [CHANNELS-1:0] rts_n_o,
   output logic [CHANNELS-1:0] dtr_n_o,
   output logic [CHANNELS-1:0] receive_ready_n_o,
   output logic [CHANNELS-1:0] transmit_ready_n_o,
   output logic [CHANNELS-1:0] int_o,
   output logic [CHANNELS-1:0] int_oe_o,
   output logic irq_n_o
);
   state_t state_reg;
   state_t state_next;
   screen_t [CHANNELS-1:0] screen;
   logic [CHANNELS-1:0] chan_int;
   logic [7:0] fifo_ready_status;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         rx_char_screen u_screen (
            .char_i(rx_char_i[g]),
            .enhanced_feature_i(state_reg.chan[g].enhanced_feature),
            .resume_one_i(state_reg.chan[g].resume_one),
            .resume_two_i(state_reg.chan[g].resume_two),
            .stop_one_i(state_reg.chan[g].stop_one),
            .stop_two_i(state_reg.chan[g].stop_two),
            .screen_o(screen[g])
         );
         assign chan_int[g] = state_reg.chan[g].flag_trigger | state_reg.chan[g].flag_special
            | state_reg.chan[g].flag_stop;
         assign rx_fifo_write_o[g] = state_reg.chan[g].store;
         assign rx_fifo_wdata_o[g] = state_reg.chan[g].store_data;
         // Transmit gate from CTS and from received stop characters
         assign tx_enable_o[g] = ~(state_reg.chan[g].enhanced_feature[EF_AUTO_CTS]
            & state_reg.pins[g]) & ~state_reg.chan[g].sw_stopped;
         assign tx_o[g] = state_reg.chan[g].tx_line;
         assign infrared_tx_out_o[g] = state_reg.chan[g].infrared_tx_out_line;
         // RTS from modem control, raised by the level watch
         assign rts_n_o[g] = ~state_reg.chan[g].modem_control[MC_RTS]
            | (state_reg.chan[g].rts_high
            & state_reg.chan[g].enhanced_feature[EF_AUTO_RTS]);
         assign dtr_n_o[g] = ~state_reg.chan[g].modem_control[MC_DTR];
         assign receive_ready_n_o[g] = state_reg.chan[g].rx_ready_n;
         assign transmit_ready_n_o[g] = state_reg.chan[g].tx_ready_n;
         assign int_o[g] = chan_int[g];
         assign int_oe_o[g] = state_reg.chan[g].modem_control[MC_INT_OUT_EN];
         assign fifo_ready_status[g] = ~state_reg.chan[g].tx_ready_n;
         assign fifo_ready_status[g + CHANNELS] = state_reg.chan[g].rx_ready_n;
      end
   endgenerate

   // 68 mode request line, active low
   assign irq_n_o = ~(state_reg.pins[SYNC_W-2] & ~state_reg.pins[SYNC_W-1] & (|chan_int));
   assign bus_rdata_o = state_reg.rdata;
   assign bus_rdata_oe_o = ~bus_i.rd_n & (~bus_i.cs_n | ~fifo_status_select_n_i);

   always_comb begin
      logic [SYNC_W-1:0] raw;
      logic rd_now;
      logic rd_first;
      logic wr_now;
      logic [7:0] lvl;
      logic [7:0] hyst;
      logic [7:0] upper;
      logic [7:0] lower;
      logic [7:0] rsel;
      raw = '0;
      rd_now = 1'b0;
      rd_first = 1'b0;
      wr_now = 1'b0;
      lvl = '0;
      hyst = '0;
      upper = '0;
      lower = '0;
      rsel = '0;
      state_next = state_reg;
      raw = {interrupt_output_select_i, mode_68_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      state_next.sync1 = raw;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      for (int b = 0; b < SYNC_W; b++) begin
         if (state_reg.sync2[b] == state_reg.sync3[b]) begin
            state_next.pins[b] = state_reg.sync3[b];
         end
      end
      rd_now = ~bus_i.cs_n & ~bus_i.rd_n;
      rd_first = rd_now & ~state_reg.rd_prev;
      wr_now = ~bus_i.cs_n & ~bus_i.wr_n;
      state_next.rd_prev = rd_now;
      for (int c = 0; c < CHANNELS; c++) begin
         lvl = rx_fifo_level_i[c];
         state_next.chan[c].tx_line = tx_bit_i[c];
         state_next.chan[c].infrared_tx_out_line = infrared_tx_out_bit_i[c];
         state_next.chan[c].rx_ready_n = (lvl == 8'h00);
         state_next.chan[c].tx_ready_n = tx_fifo_full_i[c];
         state_next.chan[c].line_status = {1'b0, tx_empty_i[c], tx_empty_i[c], 4'h0, (lvl != 8'h00)};
         state_next.chan[c].store = screen[c].store;
         state_next.chan[c].store_data = rx_char_i[c].data;
         // Read clear before deltas, so a new delta wins
         if (rd_first && bus_i.chan == 2'(c) && bus_i.addr == OFS_MODEM_STATUS) begin
            state_next.chan[c].modem_status[3:0] = 4'h0;
         end
         // Modem input deltas
         for (int m = 0; m < 4; m++) begin
            state_next.chan[c].modem_status[4 + m] = ~state_reg.pins[c + CHANNELS * m];
            if (state_reg.pins[c + CHANNELS * m] != ~state_reg.chan[c].modem_status[4 + m]) begin
               state_next.chan[c].modem_status[m] = 1'b1;
            end
         end
         if (screen[c].stop_hit) begin
            state_next.chan[c].sw_stopped = 1'b1;
         end else if (screen[c].resume_hit) begin
            state_next.chan[c].sw_stopped = 1'b0;
         end
         // Hysteresis band around the trigger level
         hyst = (state_reg.chan[c].feature_control[1:0] == 2'b00) ? HYST_NEXT
            : 8'(HYST_STEP * state_reg.chan[c].feature_control[1:0]);
         upper = 8'(state_reg.chan[c].trigger_level + hyst);
         lower = (state_reg.chan[c].trigger_level > hyst) ? 8'(state_reg.chan[c].trigger_level - hyst) : 8'h00;
         state_next.chan[c].above_trigger = (lvl >= state_reg.chan[c].trigger_level);
         if (state_reg.chan[c].enhanced_feature[EF_AUTO_RTS] && state_reg.chan[c].modem_control[MC_RTS]) begin
            if (lvl >= upper) begin
               state_next.chan[c].rts_high = 1'b1;
            end else if (lvl < lower) begin
               state_next.chan[c].rts_high = 1'b0;
            end
         end else begin
            state_next.chan[c].rts_high = 1'b0;
         end
         // Sticky flags, cleared by the first read cycle of interrupt_status
         if (rd_first && bus_i.chan == 2'(c) && bus_i.addr == OFS_INT_STATUS) begin
            state_next.chan[c].flag_trigger = 1'b0;
            state_next.chan[c].flag_special = 1'b0;
            state_next.chan[c].flag_stop = 1'b0;
         end
         if (state_reg.chan[c].int_enable[IE_RX_TRIGGER]
               && (lvl >= state_reg.chan[c].trigger_level) && !state_reg.chan[c].above_trigger) begin
            state_next.chan[c].flag_trigger = 1'b1;
         end
         if (screen[c].special && state_reg.chan[c].enhanced_feature[1:0] == RXF_PAIR_TWO) begin
            state_next.chan[c].flag_stop = 1'b1;
            if (state_reg.chan[c].int_enable[IE_SPECIAL]) begin
               state_next.chan[c].flag_special = 1'b1;
            end
         end else if (screen[c].special) begin
            state_next.chan[c].flag_special = 1'b1;
         end
         if (wr_now && bus_i.chan == 2'(c)) begin
            case (bus_i.addr)
               OFS_INT_ENABLE: state_next.chan[c].int_enable = bus_i.wdata;
               OFS_MODEM_CONTROL: state_next.chan[c].modem_control = bus_i.wdata;
               OFS_SCRATCHPAD: state_next.chan[c].scratchpad = bus_i.wdata;
               OFS_FEATURE_CONTROL: state_next.chan[c].feature_control = bus_i.wdata;
               OFS_TRIGGER_LEVEL: state_next.chan[c].trigger_level = bus_i.wdata;
               OFS_ENHANCED_FEATURE: state_next.chan[c].enhanced_feature = bus_i.wdata;
               OFS_RESUME_ONE: state_next.chan[c].resume_one = bus_i.wdata;
               OFS_RESUME_TWO: state_next.chan[c].resume_two = bus_i.wdata;
               OFS_STOP_ONE: state_next.chan[c].stop_one = bus_i.wdata;
               OFS_STOP_TWO: state_next.chan[c].stop_two = bus_i.wdata;
               default: begin
               end
            endcase
         end
      end
      // Read data mux for the addressed channel
      case (bus_i.addr)
         OFS_INT_ENABLE: rsel = state_reg.chan[bus_i.chan].int_enable;
         OFS_INT_STATUS: begin
            rsel = 8'h00;
            rsel[IS_NONE] = ~chan_int[bus_i.chan];
            rsel[IS_RX_TRIGGER] = state_reg.chan[bus_i.chan].flag_trigger;
            rsel[IS_SPECIAL] = state_reg.chan[bus_i.chan].flag_special;
            rsel[IS_STOP] = state_reg.chan[bus_i.chan].flag_stop;
         end
         OFS_MODEM_CONTROL: rsel = state_reg.chan[bus_i.chan].modem_control;
         OFS_LINE_STATUS: rsel = state_reg.chan[bus_i.chan].line_status;
         OFS_MODEM_STATUS: rsel = state_reg.chan[bus_i.chan].modem_status;
         OFS_SCRATCHPAD: rsel = state_reg.chan[bus_i.chan].scratchpad;
         OFS_FEATURE_CONTROL: rsel = state_reg.chan[bus_i.chan].feature_control;
         OFS_TRIGGER_LEVEL: rsel = state_reg.chan[bus_i.chan].trigger_level;
         OFS_ENHANCED_FEATURE: rsel = state_reg.chan[bus_i.chan].enhanced_feature;
         OFS_RESUME_ONE: rsel = state_reg.chan[bus_i.chan].resume_one;
         OFS_RESUME_TWO: rsel = state_reg.chan[bus_i.chan].resume_two;
         OFS_STOP_ONE: rsel = state_reg.chan[bus_i.chan].stop_one;
         OFS_STOP_TWO: rsel = state_reg.chan[bus_i.chan].stop_two;
         default: rsel = 8'h00;
      endcase
      if (!bus_i.rd_n && !fifo_status_select_n_i) begin
         state_next.rdata = fifo_ready_status;
      end else if (rd_now) begin
         state_next.rdata = rsel;
      end
      if (rst_i) begin
         state_next = '0;
         state_next.sync1 = raw;
         state_next.sync2 = raw;
         state_next.sync3 = raw;
         state_next.pins = raw;
         for (int c = 0; c < CHANNELS; c++) begin
            state_next.chan[c].line_status = RST_LINE_STATUS;
            state_next.chan[c].scratchpad = RST_SCRATCHPAD;
            state_next.chan[c].modem_status = {~raw[c + 3 * CHANNELS], ~raw[c + 2 * CHANNELS],
               ~raw[c + CHANNELS], ~raw[c], 4'h0};
            state_next.chan[c].rx_ready_n = RST_FIFO_READY[c + CHANNELS];
            state_next.chan[c].tx_ready_n = ~RST_FIFO_READY[c];
            state_next.chan[c].tx_line = 1'b1;
            state_next.chan[c].infrared_tx_out_line = 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      state_reg <= state_next;
   end
endmodule // uart_enhanced_flow_control

/* tb/uart_ef_properties.sv */
// Port checker for the enhanced flow control block
module uart_ef_properties
   import uart_ef_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire bus_req_t bus_i,
   input wire logic fifo_status_select_n_i,
   input wire logic [7:0] bus_rdata_o,
   input wire logic bus_rdata_oe_o,
   input wire rx_char_t [CHANNELS-1:0] rx_char_i,
   input wire logic [CHANNELS-1:0][7:0] rx_fifo_level_i,
   input wire logic [CHANNELS-1:0] cts_n_i,
   input wire logic [CHANNELS-1:0] rx_fifo_write_o,
   input wire logic [CHANNELS-1:0][7:0] rx_fifo_wdata_o,
   input wire logic [CHANNELS-1:0] tx_enable_o,
   input wire logic [CHANNELS-1:0] tx_o,
   input wire logic [CHANNELS-1:0] rts_n_o,
   input wire logic [CHANNELS-1:0] receive_ready_n_o,
   input wire logic [CHANNELS-1:0] transmit_ready_n_o,
   input wire logic [CHANNELS-1:0] int_o,
   input wire logic [CHANNELS-1:0] int_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh [16];
   // Shadow of channel A register writes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sh <= '{default: 8'h00};
      end else if (!bus_i.cs_n && !bus_i.wr_n && bus_i.chan == 2'd0) begin
         sh[bus_i.addr] <= bus_i.wdata;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   read_enable_a: assert property (bus_rdata_oe_o == (!bus_i.rd_n && (!bus_i.cs_n || !fifo_status_select_n_i)))
      else $error("read enable wrong");
   fifo_status_a: assert property (!bus_i.rd_n && !fifo_status_select_n_i |=>
      bus_rdata_o == {$past(receive_ready_n_o), ~$past(transmit_ready_n_o)}) else $error("fifo status wrong");
   store_data_a: assert property (rx_fifo_write_o[0] |->
      $past(rx_char_i[0].valid) && rx_fifo_wdata_o[0] == $past(rx_char_i[0].data)) else $error("stored data wrong");
   special_hit_a: assert property (rx_char_i[0].valid && sh[8] == 8'h20 && rx_char_i[0].data == sh[12] |=>
      rx_fifo_write_o[0] && int_o[0]) else $error("special char missed");
   pair_two_a: assert property (rx_char_i[0].valid && sh[8][5] && sh[8][1:0] == 2'b01 &&
      rx_char_i[0].data == sh[12] |=> !rx_fifo_write_o[0] && int_o[0]) else $error("stop char stored");
   cts_halt_a: assert property ((sh[8][7] && cts_n_i[0])[*8] |-> !tx_enable_o[0])
      else $error("transmit not halted");
   rts_plain_a: assert property (!sh[8][6] |-> rts_n_o[0] == !sh[2][1])
      else $error("rts not from modem control");
   rts_up_a: assert property ((sh[8][6] && sh[2][1] && sh[6][1:0] == 2'b00 &&
      {1'b0, rx_fifo_level_i[0]} >= sh[7] + 9'd8)[*2] |-> rts_n_o[0]) else $error("rts not raised");
   rts_down_a: assert property ((sh[8][6] && sh[2][1] && sh[6][1:0] == 2'b00 &&
      {1'b0, rx_fifo_level_i[0]} + 9'd8 < sh[7])[*2] |-> !rts_n_o[0]) else $error("rts not lowered");
   reset_pins_a: assert property (disable iff (1'b0) rst_i |=> tx_o == 4'hf && rts_n_o == 4'hf &&
      receive_ready_n_o == 4'hf && transmit_ready_n_o == 4'h0 && int_oe_o == 4'h0) else $error("reset pins wrong");
endmodule // uart_ef_properties

/* tb/serial_peer.sv */
// Remote serial device: received characters and clear-to-send pins
module serial_peer
   import uart_ef_pkg::*;
(
   input wire logic clock_i,
   output rx_char_t [CHANNELS-1:0] rx_char_o,
   output logic [CHANNELS-1:0] cts_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rx_char_o = '0;
      cts_n_o = '0;
   end
   // One character, valid for one cycle
   task automatic send_char(input int ch, input logic [7:0] c);
      @(posedge clock_i);
      rx_char_o[ch] <= {1'b1, c};
      @(posedge clock_i);
      rx_char_o[ch] <= {1'b0, ~c};
   endtask
   task automatic set_cts(input int ch, input logic v);
      @(posedge clock_i);
      cts_n_o[ch] <= v;
   endtask
endmodule // serial_peer

/* tb/tb.sv */
// Testbench for the enhanced flow control block
module tb
   import uart_ef_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i, rst_i, fsel_n, m68, isel;
   bus_req_t bus;
   logic [CHANNELS-1:0][7:0] lvl;
   logic [3:0] txfull, txbit, rxw, txe, txo, irt, rtsn, dtrn, rrn, trn, into, inoe, cts;
   logic [7:0] rdata, d;
   logic rdoe, irqn;
   logic [3:0][7:0] rxd;
   rx_char_t [CHANNELS-1:0] rxc;
   int err_count = 0;
   int tests_run = 0;
   // Offset, written value, reset value, read back value
   logic [27:0] rows [13] = '{28'h0_20_00_20, 28'h1_ff_01_01, 28'h2_02_00_02, 28'h3_00_60_60,
      28'h4_ff_10_10, 28'h5_33_ff_33, 28'h6_00_00_00, 28'h7_10_00_10, 28'h9_11_00_11, 28'ha_13_00_13,
      28'hb_19_00_19, 28'hc_2a_00_2a, 28'hd_ff_00_00};
   uart_enhanced_flow_control i_dut (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus),
      .fifo_status_select_n_i(fsel_n), .bus_rdata_o(rdata), .bus_rdata_oe_o(rdoe), .rx_char_i(rxc),
      .rx_fifo_level_i(lvl), .tx_fifo_full_i(txfull), .tx_empty_i(4'hf), .tx_bit_i(txbit),
      .infrared_tx_out_bit_i(4'h0), .cts_n_i(cts), .dsr_n_i(4'hf), .ri_n_i(4'hf), .cd_n_i(4'hf), .mode_68_i(m68),
      .interrupt_output_select_i(isel), .rx_fifo_write_o(rxw), .rx_fifo_wdata_o(rxd), .tx_enable_o(txe),
      .tx_o(txo), .infrared_tx_out_o(irt), .rts_n_o(rtsn), .dtr_n_o(dtrn), .receive_ready_n_o(rrn),
      .transmit_ready_n_o(trn), .int_o(into), .int_oe_o(inoe), .irq_n_o(irqn));
   serial_peer i_peer (.clock_i(clock_i), .rx_char_o(rxc), .cts_n_o(cts));
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] w);
      @(posedge clock_i);
      bus <= {3'b010, 2'd0, a, w};
      @(posedge clock_i);
      bus <= {3'b111, 14'h0000};
   endtask
   // Register read, or fifo status read when fs is set
   task automatic rd(input logic [3:0] a, input logic fs, output logic [7:0] v);
      @(posedge clock_i);
      bus <= {fs, 2'b01, 2'd0, a, 8'h00};
      fsel_n <= ~fs;
      @(posedge clock_i);
      bus <= {3'b111, 14'h0000};
      fsel_n <= 1'b1;
      @(negedge clock_i);
      v = rdata;
   endtask
   task automatic snd(input logic [7:0] c, input logic st, input logic [7:0] e);
      i_peer.send_char(0, c);
      @(negedge clock_i);
      chk("fifo write", {7'h00, st}, {7'h00, rxw[0]});
      rd(4'h1, 1'b0, d);
      chk("interrupt_status", e, d);
   endtask
   task automatic lv(input logic [7:0] l, input logic r);
      @(posedge clock_i);
      lvl[0] <= l;
      repeat (3) @(posedge clock_i);
      @(negedge clock_i);
      chk("rts_n", {7'h00, r}, {7'h00, rtsn[0]});
   endtask
   task automatic cts_step(input logic v, input logic e);
      i_peer.set_cts(0, v);
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      chk("tx_enable", {7'h00, e}, {7'h00, txe[0]});
   endtask
   initial begin
      repeat (5000) @(posedge clock_i);
      err_count++;
      stop_test();
   end
   initial begin
      bus = {3'b111, 14'h0000};
      {fsel_n, m68, isel, rst_i} = 4'b1101;
      lvl = '0;
      txfull = 4'h0;
      txbit = 4'hf;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(4'h0, 1'b1, d);
      chk("fifo_ready_status", 8'hff, d);
      foreach (rows[i]) begin
         rd(rows[i][27:24], 1'b0, d);
         chk("reset value", rows[i][15:8], d);
         wr(rows[i][27:24], rows[i][23:16]);
         rd(rows[i][27:24], 1'b0, d);
         chk("read back", rows[i][7:0], d);
      end
      wr(4'h8, 8'h20);
      snd(8'h2a, 1'b1, 8'h10);
      snd(8'h54, 1'b1, 8'h01);
      wr(4'h8, 8'h00);
      wr(4'h8, 8'h21);
      snd(8'h2a, 1'b0, 8'h30);
      snd(8'h13, 1'b0, 8'h01);
      wr(4'h8, 8'h00);
      wr(4'h8, 8'h22);
      snd(8'h2a, 1'b1, 8'h10);
      snd(8'h19, 1'b0, 8'h01);
      snd(8'h11, 1'b0, 8'h01);
      wr(4'h8, 8'h00);
      wr(4'h8, 8'h03);
      snd(8'h19, 1'b0, 8'h01);
      chk("tx_enable", 8'h00, {7'h00, txe[0]});
      snd(8'h13, 1'b0, 8'h01);
      wr(4'h8, 8'h00);
      wr(4'h0, 8'h21);
      wr(4'h8, 8'h40);
      lv(8'h18, 1'b1);
      chk("irq_n", 8'h00, {7'h00, irqn});
      rd(4'h1, 1'b0, d);
      chk("interrupt_status", 8'h04, d);
      lv(8'h09, 1'b1);
      lv(8'h07, 1'b0);
      wr(4'h8, 8'h00);
      wr(4'h2, 8'h00);
      lv(8'h07, 1'b1);
      @(posedge clock_i);
      txfull <= 4'b0101;
      lvl[1] <= 8'h05;
      repeat (3) @(posedge clock_i);
      rd(4'h0, 1'b1, d);
      chk("fifo_ready_status", 8'hca, d);
      wr(4'h8, 8'h80);
      cts_step(1'b1, 1'b0);
      cts_step(1'b0, 1'b1);
      @(posedge clock_i);
      txbit <= 4'h0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      @(negedge clock_i);
      chk("tx and rts", 8'hff, {txo, rtsn});
      chk("dtr and rx ready", 8'hff, {dtrn, rrn});
      chk("infrared and tx ready", 8'h00, {irt, trn});
      chk("int enable and irq", 8'h01, {inoe, 3'h0, irqn});
      @(posedge clock_i);
      rst_i <= 1'b0;
      txbit <= 4'hf;
      rd(4'h8, 1'b0, d);
      chk("enhanced_feature", 8'h00, d);
      stop_test();
   end
endmodule // tb
bind uart_enhanced_flow_control uart_ef_properties u_chk (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus_i),
   .fifo_status_select_n_i(fifo_status_select_n_i), .bus_rdata_o(bus_rdata_o), .bus_rdata_oe_o(bus_rdata_oe_o),
   .rx_char_i(rx_char_i), .rx_fifo_level_i(rx_fifo_level_i), .cts_n_i(cts_n_i), .rx_fifo_write_o(rx_fifo_write_o),
   .rx_fifo_wdata_o(rx_fifo_wdata_o), .tx_enable_o(tx_enable_o), .tx_o(tx_o), .rts_n_o(rts_n_o),
   .receive_ready_n_o(receive_ready_n_o), .transmit_ready_n_o(transmit_ready_n_o), .int_o(int_o),
   .int_oe_o(int_oe_o));
